// file: hw/cipr_defines.svh
`ifndef CIPR_DEFINES_SVH
`define CIPR_DEFINES_SVH
// register byte offsets (low address byte)
`define CIPR_OFS_PREQ   8'h00
`define CIPR_OFS_PSTAT  8'h04
`define CIPR_OFS_IORNG  8'h08
`define CIPR_OFS_CSTCFG 8'h0c
`define CIPR_OFS_CSTAT  8'h10
// idle state codes
`define CIPR_CS_C0  4'h0
`define CIPR_CS_C1  4'h1
`define CIPR_CS_C3  4'h3
`define CIPR_CS_C6  4'h6
`define CIPR_CS_C7  4'h7
`define CIPR_CS_C10 4'ha
// legacy level read decoding
`define CIPR_LVL_C3   16'h0002
`define CIPR_LVL_C6   16'h0003
`define CIPR_LVL_MAX  16'h0007
`define CIPR_LVL_DEEP 4'h3
// register fields
`define CIPR_PREQ_PS    3:0
`define CIPR_PREQ_CORE  11:8
`define CIPR_IORNG_BASE 15:0
`define CIPR_IORNG_MAX  19:16
`define CIPR_IORNG_EN   31
`define CIPR_CFG_C3EN   0
`define CIPR_CFG_C1EN   1
`define CIPR_CFG_C3THR  15:8
`define CIPR_CFG_C1THR  23:16
`define CIPR_PSTAT_TGT  7:4
`define CIPR_PSTAT_VOLT 11:8
`define CIPR_PSTAT_BUSY 16
`define CIPR_RST_WORD   32'h0000_0000
`define CIPR_HTRANS_ACT 1
// timing
`define CIPR_CLK_NS   10
`define CIPR_VSTEP_NS 50
`define CIPR_LOCK_NS  200
`endif

// file: hw/cipr_pkg.sv
`default_nettype none
package cipr_pkg;
	// per-core idle sequencing
	typedef enum logic [2:0] {
		cipr_core_run,
		cipr_core_halt,
		cipr_core_flush,
		cipr_core_save,
		cipr_core_off,
		cipr_core_restore
	} cipr_core_type;
	// performance-state change sequencing
	typedef enum logic [1:0] {
		cipr_ps_idle,
		cipr_ps_ramp,
		cipr_ps_lock
	} cipr_ps_type;
endpackage : cipr_pkg
`default_nettype wire

// file: hw/cipr_resolver.sv
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`include "cipr_defines.svh"
`default_nettype none
// Contract
// - active cores share highest requested performance state
// - changes accepted anytime, deferred while one runs
// - voltage settles before frequency lock
// - core idle is lowest thread idle state
// - any active thread keeps core in C0
// - interrupt, monitor hit, timer wake to C0
// - targeted interrupt wakes only its thread
// - package interrupt may wake any core
// - system reset reinitializes every core
// - idle states always pass through C0
// - power actions only after core resolution
// - C1 only when all threads idle
// - C1 core keeps servicing snoops
// - C3 flushes caches then stops clocks
// - monitor wait or legacy level reads enter idle
// - C6 and deeper save state, power off
// - trapped level read becomes monitor wait
// - only reads inside range are trapped
// - redirected reads: sub-state zero, wake masked
// - two demotion options, alone or together
// - demote on high interrupt rate, rare residency
// - demotion off at reset, set by config
module cipr_resolver import cipr_pkg::*; #(
	parameter int NC      = 2,
	parameter int NT      = 2,
	parameter int WIN_CYC = 1024,
	parameter int RES_MIN = 64
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             hsel_i,
	input  wire logic [31:0]      haddr_i,
	input  wire logic [1:0]       htrans_i,
	input  wire logic             hwrite_i,
	input  wire logic [2:0]       hsize_i,
	input  wire logic [31:0]      hwdata_i,
	input  wire logic             hready_i,
	output logic      [31:0]      hrdata_o,
	output logic                  hreadyout_o,
	output logic                  hresp_o,
	input  wire logic [NC*NT-1:0] monitor_wait_request_i,
	input  wire logic [NC*NT*4-1:0] monitor_wait_hint_i,
	input  wire logic [NC*NT-1:0] halt_request_i,
	input  wire logic [NC*NT-1:0] interrupt_enable_flag_i,
	input  wire logic [NC*NT-1:0] legacy_idle_level_read_i,
	input  wire logic [NC*NT*16-1:0] io_rd_addr_i,
	input  wire logic [NC*NT-1:0] thread_intr_i,
	input  wire logic             pkg_intr_i,
	input  wire logic [NC*NT-1:0] timer_expire_i,
	input  wire logic [NC-1:0]    monitor_hit_i,
	input  wire logic [NC-1:0]    flush_done_i,
	input  wire logic [NC-1:0]    save_done_i,
	input  wire logic [NC-1:0]    restore_done_i,
	output logic      [NC*NT-1:0] io_passthru_o,
	output logic      [NC*NT*4-1:0] thread_cstate_o,
	output logic      [NC*4-1:0]  core_cstate_o,
	output logic      [NC-1:0]    flush_req_o,
	output logic      [NC-1:0]    save_req_o,
	output logic      [NC-1:0]    restore_req_o,
	output logic      [NC-1:0]    clk_stop_o,
	output logic      [NC-1:0]    pwr_off_o,
	output logic      [NC-1:0]    snoop_en_o,
	output logic      [3:0]       volt_code_o,
	output logic      [3:0]       freq_code_o,
	output logic                  pll_lock_o,
	output logic                  pstate_busy_o
);
	localparam int NTH = NC * NT;
	localparam int VSTEP_CYC = (`CIPR_VSTEP_NS + `CIPR_CLK_NS - 1) / `CIPR_CLK_NS;
	localparam int LOCK_CYC = (`CIPR_LOCK_NS + `CIPR_CLK_NS - 1) / `CIPR_CLK_NS;
	localparam int LOCK_MAX = LOCK_CYC + 2;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	////////////////////////////////////////////////////////////////////////////
	// register bus slave
	logic [31:0]     preq_rd_r;
	logic [NC*4-1:0] preq_r;
	logic [31:0]     iorng_r;
	logic [31:0]     cfg_r;
	logic            wr_pend_r;
	logic [7:0]      wa_r;
	logic [3:0]      volt_r;
	logic [3:0]      freq_r;
	logic [3:0]      tgt_r;
	cipr_ps_type     ps_r;
	wire logic [NTH*4-1:0] th_vec;
	wire logic [NC*4-1:0]  cs_vec;
	wire logic             acc = hsel_i && htrans_i[`CIPR_HTRANS_ACT] && hready_i;
	wire logic [7:0]       ra = haddr_i[7:0];
	wire logic [31:0]      pstat = {15'h0, ps_r != cipr_ps_idle, 4'h0, volt_r,
		tgt_r, freq_r};
	wire logic [31:0]      cstat = {16'(th_vec), 16'(cs_vec)};
	// read decode, unmapped offsets read zero
	wire logic [31:0] rd_mux = (ra == `CIPR_OFS_PREQ)   ? preq_rd_r :
		(ra == `CIPR_OFS_PSTAT)  ? pstat :
		(ra == `CIPR_OFS_IORNG)  ? iorng_r :
		(ra == `CIPR_OFS_CSTCFG) ? cfg_r :
		(ra == `CIPR_OFS_CSTAT)  ? cstat : `CIPR_RST_WORD;
	wire logic wr_preq = wr_pend_r && wa_r == `CIPR_OFS_PREQ;

	// address phase capture, zero-wait OKAY answers
	always_ff @(posedge clk_i)
	begin
		wr_pend_r   <= !reset_i && acc && hwrite_i;
		wa_r        <= reset_i ? 8'h00 : ra;
		hrdata_o    <= (!reset_i && acc && !hwrite_i) ? rd_mux : `CIPR_RST_WORD;
		hreadyout_o <= 1'b1;
		hresp_o     <= 1'b0;
	end

	// configuration registers written in the data phase
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			iorng_r   <= `CIPR_RST_WORD;
			cfg_r     <= `CIPR_RST_WORD;
			preq_rd_r <= `CIPR_RST_WORD;
		end
		else if (wr_pend_r)
		begin
			if (wa_r == `CIPR_OFS_IORNG)
				iorng_r <= hwdata_i;
			if (wa_r == `CIPR_OFS_CSTCFG)
				cfg_r <= hwdata_i;
			if (wa_r == `CIPR_OFS_PREQ)
				preq_rd_r <= hwdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// thread idle requests and wakes
	wire logic [NTH-1:0] trap_w;
	wire logic [NTH-1:0] pass_w;
	for (genvar t = 0; t < NTH; t++)
	begin : g_thr
		localparam int C = t / NT;
		logic [3:0] st_r;
		logic       mw_r;
		logic       brk_r;
		wire logic [15:0] addr = io_rd_addr_i[t*16 +: 16];
		wire logic [15:0] base = iorng_r[`CIPR_IORNG_BASE];
		wire logic [15:0] lvl = addr - base;
		wire logic [15:0] lmax = 16'(iorng_r[`CIPR_IORNG_MAX]);
		// only level reads inside the configured window are trapped
		wire logic trap = iorng_r[`CIPR_IORNG_EN] && addr >= base
			&& lvl >= `CIPR_LVL_C3 && lvl <= lmax && lvl <= `CIPR_LVL_MAX;
		wire logic [3:0] lvl_cs = (lvl == `CIPR_LVL_C3) ? `CIPR_CS_C3 :
			(lvl == `CIPR_LVL_C6) ? `CIPR_CS_C6 : lvl[3:0] + `CIPR_LVL_DEEP;
		wire logic io_req = legacy_idle_level_read_i[t] && trap;
		wire logic [3:0] hint = monitor_wait_hint_i[t*4 +: 4];
		wire logic mreq = monitor_wait_request_i[t] && hint != `CIPR_CS_C0;
		wire logic pkg_w = pkg_intr_i && (t % NT == 0);
		// a masked interrupt wakes only redirected waits
		wire logic wake = (thread_intr_i[t] && (interrupt_enable_flag_i[t] || brk_r))
			|| timer_expire_i[t] || (monitor_hit_i[C] && mw_r) || pkg_w;
		wire logic [3:0] req_cs = io_req ? lvl_cs : mreq ? hint :
			halt_request_i[t] ? `CIPR_CS_C1 : `CIPR_CS_C0;
		// idle threads only return to C0, new requests only from C0
		wire logic [3:0] nxt = (st_r != `CIPR_CS_C0) ? (wake ? `CIPR_CS_C0 : st_r)
			: req_cs;
		always_ff @(posedge clk_i)
		begin
			st_r <= reset_i ? `CIPR_CS_C0 : nxt;
			if (reset_i || st_r != `CIPR_CS_C0)
			begin
				mw_r  <= reset_i ? 1'b0 : mw_r;
				brk_r <= reset_i ? 1'b0 : brk_r;
			end
			else
			begin
				mw_r  <= io_req || mreq;
				brk_r <= io_req;
			end
		end
		assign th_vec[t*4 +: 4] = nxt;
		assign trap_w[t] = trap;
		assign pass_w[t] = legacy_idle_level_read_i[t] && !trap;
	end

	////////////////////////////////////////////////////////////////////////////
	// per-core resolution, demotion and power sequencing
	wire logic [NC-1:0] act_w;
	wire logic [NC-1:0] fl_w;
	wire logic [NC-1:0] sv_w;
	wire logic [NC-1:0] rs_w;
	wire logic [NC-1:0] cs_w;
	wire logic [NC-1:0] po_w;
	wire logic [NC-1:0] sn_w;
	logic [WIN_CYC > 1 ? $clog2(WIN_CYC)-1 : 0 : 0] win_r;
	wire logic win_end = win_r == ($bits(win_r))'(WIN_CYC - 1);

	// shared residency sampling window
	always_ff @(posedge clk_i)
	begin
		win_r <= (reset_i || win_end) ? '0 : win_r + 1'b1;
	end

	for (genvar c = 0; c < NC; c++)
	begin : g_core
		logic [3:0]    res;
		logic [3:0]    dep_r;
		logic [7:0]    irq_r;
		logic [7:0]    rate_r;
		logic [15:0]   deep_r;
		logic          rare_r;
		cipr_core_type st_r;
		cipr_core_type nxt;
		wire logic [NT-1:0] thr_irq = thread_intr_i[c*NT +: NT];
		wire logic [7:0] c3_thr = cfg_r[`CIPR_CFG_C3THR];
		wire logic [7:0] c1_raw = cfg_r[`CIPR_CFG_C1THR];
		// the C1 option always needs a strictly higher rate
		wire logic [8:0] c1_thr = (c1_raw > c3_thr) ? {1'b0, c1_raw}
			: {1'b0, c3_thr} + 9'h001;
		wire logic hot1 = rare_r && {1'b0, rate_r} >= c1_thr;
		wire logic hot3 = rare_r && rate_r >= c3_thr;
		wire logic d1 = cfg_r[`CIPR_CFG_C1EN] && hot1 && (res == `CIPR_CS_C3
			|| res == `CIPR_CS_C6 || res == `CIPR_CS_C7);
		wire logic d3 = cfg_r[`CIPR_CFG_C3EN] && hot3 && (res == `CIPR_CS_C6
			|| res == `CIPR_CS_C7);
		wire logic [3:0] dem = d1 ? `CIPR_CS_C1 : d3 ? `CIPR_CS_C3 : res;
		wire logic go = st_r == cipr_core_run && res != `CIPR_CS_C0;
		wire logic [3:0] dep_nxt = go ? dem : dep_r;
		wire logic deep = dep_nxt >= `CIPR_CS_C6;

		// lowest thread state; any active thread gives C0
		always_comb
		begin
			res = `CIPR_CS_C10;
			for (int k = 0; k < NT; k++)
				if (th_vec[(c*NT+k)*4 +: 4] < res)
					res = th_vec[(c*NT+k)*4 +: 4];
		end

		// idle entry and exit sequence
		always_comb
		begin
			case (st_r)
				cipr_core_run:
					nxt = !go ? cipr_core_run : (dem == `CIPR_CS_C1) ? cipr_core_halt
						: cipr_core_flush;
				cipr_core_halt:
					nxt = (res == `CIPR_CS_C0) ? cipr_core_run : cipr_core_halt;
				cipr_core_flush:
					nxt = !flush_done_i[c] ? cipr_core_flush
						: deep ? cipr_core_save : cipr_core_off;
				cipr_core_save:
					nxt = save_done_i[c] ? cipr_core_off : cipr_core_save;
				cipr_core_off:
					nxt = (res != `CIPR_CS_C0) ? cipr_core_off
						: deep ? cipr_core_restore : cipr_core_run;
				cipr_core_restore:
					nxt = restore_done_i[c] ? cipr_core_run : cipr_core_restore;
				default:
					nxt = cipr_core_run;
			endcase
		end

		// state, depth and residency history
		always_ff @(posedge clk_i)
		begin
			st_r  <= reset_i ? cipr_core_run : nxt;
			dep_r <= reset_i ? `CIPR_CS_C0 : dep_nxt;
			if (reset_i || win_end)
			begin
				irq_r  <= 8'h00;
				deep_r <= 16'h0000;
				rate_r <= reset_i ? 8'h00 : irq_r;
				rare_r <= reset_i ? 1'b0 : deep_r < 16'(RES_MIN);
			end
			else
			begin
				irq_r  <= (|thr_irq && irq_r != 8'hff) ? irq_r + 8'h01 : irq_r;
				deep_r <= (st_r == cipr_core_off && dep_r >= `CIPR_CS_C3
					&& deep_r != 16'hffff) ? deep_r + 16'h0001 : deep_r;
			end
		end

		assign cs_vec[c*4 +: 4] = (nxt == cipr_core_run) ? `CIPR_CS_C0 : dep_nxt;
		assign act_w[c] = st_r == cipr_core_run;
		assign fl_w[c] = nxt == cipr_core_flush;
		assign sv_w[c] = nxt == cipr_core_save;
		assign rs_w[c] = nxt == cipr_core_restore;
		assign cs_w[c] = nxt == cipr_core_off || nxt == cipr_core_save;
		assign po_w[c] = nxt == cipr_core_off && deep;
		assign sn_w[c] = nxt == cipr_core_run || nxt == cipr_core_halt;
	end

	// registered core and thread outputs
	always_ff @(posedge clk_i)
	begin
		io_passthru_o   <= reset_i ? '0 : pass_w;
		thread_cstate_o <= reset_i ? '0 : th_vec;
		core_cstate_o   <= reset_i ? '0 : cs_vec;
		flush_req_o     <= reset_i ? '0 : fl_w;
		save_req_o      <= reset_i ? '0 : sv_w;
		restore_req_o   <= reset_i ? '0 : rs_w;
		clk_stop_o      <= reset_i ? '0 : cs_w;
		pwr_off_o       <= reset_i ? '0 : po_w;
		snoop_en_o      <= reset_i ? '1 : sn_w;
	end

	////////////////////////////////////////////////////////////////////////////
	// performance-state arbitration and sequencing
	logic [3:0]  want;
	logic [15:0] cnt_r;

	// highest request among active cores
	always_comb
	begin
		want = freq_r;
		if (|act_w)
			want = 4'h0;
		for (int k = 0; k < NC; k++)
			if (act_w[k] && preq_r[k*4 +: 4] > want)
				want = preq_r[k*4 +: 4];
	end

	// per-core request table
	always_ff @(posedge clk_i)
	begin
		for (int k = 0; k < NC; k++)
			if (reset_i)
				preq_r[k*4 +: 4] <= 4'h0;
			else if (wr_preq && hwdata_i[`CIPR_PREQ_CORE] == 4'(k))
				preq_r[k*4 +: 4] <= hwdata_i[`CIPR_PREQ_PS];
	end

	// ramp voltage stepwise, then lock frequency
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ps_r   <= cipr_ps_idle;
			volt_r <= 4'h0;
			freq_r <= 4'h0;
			tgt_r  <= 4'h0;
			cnt_r  <= 16'h0000;
		end
		else
		begin
			case (ps_r)
				cipr_ps_idle:
					if (want != freq_r)
					begin
						tgt_r <= want;
						ps_r  <= cipr_ps_ramp;
						cnt_r <= 16'h0000;
					end
				cipr_ps_ramp:
					if (volt_r == tgt_r)
					begin
						ps_r  <= cipr_ps_lock;
						cnt_r <= 16'h0000;
					end
					else if (cnt_r == 16'(VSTEP_CYC - 1))
					begin
						volt_r <= (volt_r < tgt_r) ? volt_r + 4'h1 : volt_r - 4'h1;
						cnt_r  <= 16'h0000;
					end
					else
						cnt_r <= cnt_r + 16'h0001;
				cipr_ps_lock:
					if (cnt_r == 16'(LOCK_CYC - 1))
					begin
						freq_r <= tgt_r;
						ps_r   <= cipr_ps_idle;
					end
					else
						cnt_r <= cnt_r + 16'h0001;
				default:
					ps_r <= cipr_ps_idle;
			endcase
		end
	end

	// registered performance outputs
	always_ff @(posedge clk_i)
	begin
		volt_code_o   <= reset_i ? 4'h0 : volt_r;
		freq_code_o   <= reset_i ? 4'h0 : freq_r;
		pll_lock_o    <= !reset_i && ps_r == cipr_ps_lock;
		pstate_busy_o <= !reset_i && ps_r != cipr_ps_idle;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_ramp_done;
		ps_r == cipr_ps_ramp ##1 ps_r == cipr_ps_lock;
	endsequence
	AST_VOLT_FIRST: assert property (ps_r == cipr_ps_lock |-> volt_r == tgt_r)
		else $error("lock started before voltage settled");
	AST_LOCK_TIME: assert property (s_ramp_done |-> ##[1:LOCK_MAX] freq_r == tgt_r)
		else $error("frequency did not lock in time");
	AST_DEFER: assert property (ps_r != cipr_ps_idle |=> tgt_r == $past(tgt_r))
		else $error("target changed during a transition");
	AST_ACTIVE_C0: assert property (th_vec[3:0] == `CIPR_CS_C0 |-> g_core[0].res == `CIPR_CS_C0)
		else $error("core not C0 with an active thread");
	AST_VIA_C0: assert property (g_thr[0].st_r != `CIPR_CS_C0
		|=> g_thr[0].st_r == $past(g_thr[0].st_r) || g_thr[0].st_r == `CIPR_CS_C0)
		else $error("thread moved between idle states");
	AST_TIMER_WAKE: assert property (timer_expire_i[0] && g_thr[0].st_r != `CIPR_CS_C0
		|=> g_thr[0].st_r == `CIPR_CS_C0 && thread_cstate_o[3:0] == `CIPR_CS_C0)
		else $error("timer expiry did not wake thread");
	AST_ONE_THREAD: assert property (g_thr[1].st_r != `CIPR_CS_C0 && thread_intr_i[0]
		&& !thread_intr_i[1] && !timer_expire_i[1] && !monitor_hit_i[0] && !pkg_intr_i
		|=> $stable(g_thr[1].st_r))
		else $error("targeted interrupt woke another thread");
	AST_NO_DEMOTE: assert property (cfg_r == `CIPR_RST_WORD && g_core[0].go
		|=> g_core[0].dep_r == $past(g_core[0].res))
		else $error("demotion while disabled");
	AST_SAVE_OFF: assert property (g_core[0].st_r == cipr_core_save && save_done_i[0]
		|=> ##1 pwr_off_o[0] && clk_stop_o[0])
		else $error("core not powered off after save");
	AST_PASSTHRU: assert property (legacy_idle_level_read_i[0] && !trap_w[0]
		|=> io_passthru_o[0])
		else $error("untrapped level read not passed through");
endmodule : cipr_resolver
`default_nettype wire

// file: testbench/core_idle_perf_state_resolver_tb.sv
`include "cipr_defines.svh"
`default_nettype none
module core_idle_perf_state_resolver_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i    = 1'b0;
	logic        reset_i  = 1'b1;
	logic        hsel_i   = 1'b0;
	logic        hwrite_i = 1'b0;
	logic        pin      = 1'b0;
	logic [1:0]  htrans_i = 2'h0;
	logic [31:0] haddr_i  = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [3:0]  mwr      = 4'h0;
	logic [3:0]  hrq      = 4'h0;
	logic [3:0]  lrd      = 4'h0;
	logic [3:0]  tin      = 4'h0;
	logic [3:0]  tmr      = 4'h0;
	logic [3:0]  ief      = 4'hf;
	logic [1:0]  mhit     = 2'h0;
	logic [1:0]  fdn      = 2'h0;
	logic [1:0]  sdn      = 2'h0;
	logic [1:0]  rdn      = 2'h0;
	logic [15:0] hint     = 16'h0;
	logic [63:0] ioa      = 64'h0;
	logic        hrdy;
	logic        hresp;
	logic        lock;
	logic        busy;
	logic [31:0] hrdata;
	logic [3:0]  pthru;
	logic [3:0]  volt;
	logic [3:0]  freq;
	logic [3:0]  exp_tgt  = 4'h0;
	logic [15:0] tcs;
	logic [7:0]  ccs;
	logic [7:0]  pcs      = 8'h0;
	logic [1:0]  frq;
	logic [1:0]  svq;
	logic [1:0]  rsq;
	logic [1:0]  cstop;
	logic [1:0]  poff;
	logic [1:0]  snp;
	int          error_cnt = 0;
	int          checks    = 0;
	int          pt_cnt    = 0;

	// short window and residency figures keep demotion runs brief
	cipr_resolver #(.NC(2), .NT(2), .WIN_CYC(32), .RES_MIN(4)) cipr_resolver_inst (
		.clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
		.hwdata_i, .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
		.monitor_wait_request_i(mwr), .monitor_wait_hint_i(hint), .halt_request_i(hrq),
		.interrupt_enable_flag_i(ief), .legacy_idle_level_read_i(lrd), .io_rd_addr_i(ioa),
		.thread_intr_i(tin), .pkg_intr_i(pin), .timer_expire_i(tmr), .monitor_hit_i(mhit),
		.flush_done_i(fdn), .save_done_i(sdn), .restore_done_i(rdn), .io_passthru_o(pthru),
		.thread_cstate_o(tcs), .core_cstate_o(ccs), .flush_req_o(frq), .save_req_o(svq),
		.restore_req_o(rsq), .clk_stop_o(cstop), .pwr_off_o(poff), .snoop_en_o(snp),
		.volt_code_o(volt), .freq_code_o(freq), .pll_lock_o(lock), .pstate_busy_o(busy)
	);

	// clock of 10 ns
	always #5 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////////
	// comparison, verdict and bounded waits
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict

	task automatic tmo;
		error_cnt++;
		print_verdict();
	endtask : tmo

	// wait for a condition, ending at a falling edge
	task automatic wfor(input int s, input int c);
		logic hit;
		for (int n = 0; n < 3000; n++)
		begin
			@(negedge clk_i);
			case (s)
				0: hit = !busy;
				1: hit = frq[c];
				2: hit = svq[c];
				3: hit = rsq[c];
				4: hit = cstop[c];
				default: hit = (freq == exp_tgt);
			endcase
			if (hit === 1'b1)
				return;
		end
		tmo();
	endtask : wfor

	task automatic sn(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask : sn

	// one single-word bus transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic rdy;
		@(posedge clk_i);
		hsel_i   <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i  <= {24'h0, a};
		hwrite_i <= w;
		for (int p = 0; p < 2; p++)
		begin
			rdy = 1'b0;
			for (int n = 0; n < 50 && rdy !== 1'b1; n++)
			begin
				@(negedge clk_i);
				rdy = hrdy;
				r = hrdata;
				@(posedge clk_i);
			end
			if (rdy !== 1'b1)
				tmo();
			hsel_i   <= 1'b0;
			htrans_i <= 2'h0;
			hwdata_i <= d;
		end
	endtask : bus

	// one-cycle pulse of a thread or core event, then a quiet edge
	task automatic pls(input int k, input int t, input logic [15:0] v);
		@(posedge clk_i);
		hint <= {4{v[3:0]}};
		ioa  <= {4{v}};
		case (k)
			0: mwr[t] <= 1'b1;
			1: hrq[t] <= 1'b1;
			2: lrd[t] <= 1'b1;
			3: tin[t] <= 1'b1;
			4: tmr[t] <= 1'b1;
			5: mhit[t] <= 1'b1;
			6: pin <= 1'b1;
			7: fdn[t] <= 1'b1;
			8: sdn[t] <= 1'b1;
			default: rdn[t] <= 1'b1;
		endcase
		@(posedge clk_i);
		{mwr, hrq, lrd, tin, tmr} <= 20'h0;
		{mhit, fdn, sdn, rdn, pin} <= 9'h0;
		@(posedge clk_i);
	endtask : pls

	// pass-through pulse count, voltage at lock, idle-to-idle moves
	always @(posedge clk_i)
	begin
		pcs <= ccs;
		pt_cnt <= pt_cnt + int'(|pthru);
		if (lock === 1'b1)
			chk(volt, exp_tgt);
		for (int c = 0; c < 8; c += 4)
			if (pcs[c+:4] != 4'h0 && ccs[c+:4] != 4'h0 && pcs[c+:4] != ccs[c+:4])
				chk(ccs, pcs);
	end

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		logic [31:0] r;
		@(negedge clk_i);
		chk({ccs, tcs, snp, busy, lock, freq}, {24'h0, 2'h3, 6'h0});
		chk({hrdy, hresp}, 2'h2);
		bus(0, `CIPR_OFS_CSTCFG, 0, r);
		chk(r, 0);
		bus(0, `CIPR_OFS_PSTAT, 0, r);
		chk(r, 0);
		bus(1, 8'h40, 32'h1234_5678, r);
		bus(0, 8'h40, 0, r);
		chk(r, 0);
	endtask : t_reset

	task automatic t_pstate;
		logic [31:0] r;
		exp_tgt = 4'h3;
		bus(1, `CIPR_OFS_PREQ, 32'h0000_0003, r);
		sn(2);
		chk(busy, 1);
		bus(1, `CIPR_OFS_PREQ, 32'h0000_0109, r);
		wfor(5, 0);
		exp_tgt = 4'h9;
		wfor(5, 0);
		wfor(0, 0);
		bus(0, `CIPR_OFS_PSTAT, 0, r);
		chk(r, 32'h0000_0999);
		pls(1, 2, 0);
		sn(1);
		chk(ccs[7:4], 0);
		// a halted core leaves the vote, so core 0's request takes over
		exp_tgt = 4'h3;
		pls(1, 3, 0);
		sn(2);
		chk({ccs[7:4], snp[1], cstop[1]}, 6'h06);
		wfor(5, 0);
		exp_tgt = 4'h2;
		bus(1, `CIPR_OFS_PREQ, 32'h0000_0002, r);
		sn(2);
		wfor(0, 0);
		chk(freq, 2);
		exp_tgt = 4'h9;
		pls(3, 2, 0);
		sn(0);
		chk(tcs[15:8], 8'h10);
		pls(3, 3, 0);
		sn(2);
		chk(ccs, 0);
	endtask : t_pstate

	task automatic t_legacy;
		logic [31:0] r;
		int p;
		@(posedge clk_i);
		ief <= 4'h0;
		bus(1, `CIPR_OFS_IORNG, 32'h8007_0400, r);
		bus(0, `CIPR_OFS_IORNG, 0, r);
		chk(r, 32'h8007_0400);
		for (int l = 2; l < 8; l++)
		begin
			p = pt_cnt;
			pls(2, 0, 16'h0400 + 16'(l));
			sn(0);
			chk(tcs[3:0], l == 2 ? 3 : l + 3);
			chk(pt_cnt - p, 0);
			chk(ccs[3:0], 0);
			pls(3, 0, 0);
			sn(0);
			chk(tcs[3:0], 0);
		end
		for (int i = 0; i < 3; i++)
		begin
			p = pt_cnt;
			pls(2, 1, i == 0 ? 16'h0401 : i == 1 ? 16'h0408 : 16'h03ff);
			sn(0);
			chk(pt_cnt - p, 1);
			chk(tcs[7:4], 0);
		end
		@(posedge clk_i);
		ief <= 4'hf;
	endtask : t_legacy

	task automatic t_deep;
		pls(0, 0, 3);
		sn(1);
		chk(frq[0], 0);
		pls(0, 1, 3);
		wfor(1, 0);
		chk({cstop[0], poff[0]}, 0);
		pls(7, 0, 0);
		wfor(4, 0);
		sn(1);
		chk({ccs[3:0], poff[0], svq[0]}, 6'h0c);
		pls(5, 0, 0);
		sn(2);
		chk({ccs[3:0], cstop[0]}, 0);
		pls(0, 0, 6);
		pls(0, 1, 6);
		wfor(1, 0);
		pls(7, 0, 0);
		wfor(2, 0);
		chk(poff[0], 0);
		pls(8, 0, 0);
		sn(2);
		chk({ccs[3:0], cstop[0], poff[0]}, 6'h1b);
		pls(4, 0, 0);
		pls(4, 1, 0);
		wfor(3, 0);
		pls(9, 0, 0);
		sn(2);
		chk({ccs[3:0], poff[0]}, 0);
	endtask : t_deep

	task automatic t_pkg;
		pls(0, 0, 6);
		pls(1, 1, 0);
		pls(0, 2, 1);
		sn(1);
		chk(ccs, 8'h01);
		pls(6, 0, 0);
		sn(0);
		chk(tcs, 16'h0010);
		pls(3, 1, 0);
		sn(1);
		chk(ccs, 0);
	endtask : t_pkg

	// busy interrupt history on core 0, then a deep request on both threads
	task automatic t_demote(input logic [31:0] cfg, input logic [3:0] exp);
		logic [31:0] r;
		bus(1, `CIPR_OFS_CSTCFG, cfg, r);
		bus(0, `CIPR_OFS_CSTCFG, 0, r);
		chk(r, cfg);
		@(posedge clk_i);
		tin <= 4'h1;
		repeat (70) @(posedge clk_i);
		tin <= 4'h0;
		pls(0, 0, 6);
		pls(0, 1, 6);
		sn(2);
		chk(ccs[3:0], exp);
		pls(7, 0, 0);
		pls(4, 0, 0);
		pls(4, 1, 0);
		sn(2);
		chk(ccs[3:0], 0);
	endtask : t_demote

	task automatic t_midreset;
		logic [31:0] r;
		pls(0, 0, 6);
		pls(0, 1, 6);
		wfor(1, 0);
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		sn(1);
		chk({ccs, tcs, frq, snp, freq}, {26'h0, 2'h3, 4'h0});
		bus(0, `CIPR_OFS_IORNG, 0, r);
		chk(r, 0);
	endtask : t_midreset

	////////////////////////////////////////////////////////////////////////////////
	// reset, then the scenarios in turn
	initial
	begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_pstate();
		t_legacy();
		t_deep();
		t_pkg();
		t_demote(32'h0028_0403, 4'h3);
		t_demote(32'h0008_0402, 4'h1);
		t_demote(32'h0000_0401, 4'h3);
		t_midreset();
		print_verdict();
	end
endmodule : core_idle_perf_state_resolver_tb
`default_nettype wire
